// ===== hpbp_pkg.sv
`default_nettype none
package hpbp_pkg;
	// Bus flavours selected by the address latch pin.
	typedef enum logic [1:0] {
		HPBP_BUS_STROBE_DIR,
		HPBP_BUS_SPLIT,
		HPBP_BUS_MUXED
	} hpbp_bus_t;

	localparam int          HPBP_DATA_W      = 8;
	localparam int          HPBP_ADDR_W      = 8;
	localparam int          HPBP_NUM_LOC     = 9;
	localparam logic [7:0]  HPBP_ADDR_RESET  = 8'h00;
	localparam logic [7:0]  HPBP_DATA_RESET  = 8'h00;
	localparam logic [7:0]  HPBP_LAST_LOC    = 8'h08;
	localparam logic [7:0]  HPBP_OE_OFF      = 8'hff;
	localparam logic [7:0]  HPBP_OE_ON       = 8'h00;
endpackage
`default_nettype wire

// ===== hpbp_strobe_edge.sv
`timescale 1ns/10ps
`default_nettype none
// Registers a level and reports its rising and falling edges in the same cycle, against the registered sample.
module hpbp_strobe_edge (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic level_in,
	input  wire logic reset_value,
	output logic      level_q,
	output logic      rise,
	output logic      fall
);
	logic level_reg;
	logic level_next;

	// The previous sample is the reference for both edges.
	always_comb begin
		level_next = level_in;
	end

	// Reset loads a fixed high idle level; the caller's reset_value is not used.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			level_reg <= 1'b1;
		end else begin
			level_reg <= level_next;
		end
	end

	assign level_q = level_reg;
	assign rise    = level_in & ~level_reg;
	assign fall    = ~level_in & level_reg;

	// The reset_value port documents the idle level; only high idles are used here.
	logic unused_reset_value;
	assign unused_reset_value = reset_value;
endmodule // hpbp_strobe_edge
`default_nettype wire

// ===== hpbp_host_port.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Eight-bit host port, multiplexed or separate address and data lines.
// - Address latch held high at reset selects strobe and direction bus.
// - Address latch held low at reset selects split read/write strobe bus.
// - Any edge on address latch after the strap clock switches to multiplexed bus at the next clock.
// - Multiplexed bus is kept until hardware reset.
// - Multiplexed: address on shared lines captured while latch is high.
// - Chip select low selects device; strobes ignored while it is high.
// - Strobe bus: direction high means read, low means write.
// - Strobe bus: write completes at data strobe rising edge.
// - Split and multiplexed buses: read strobe reads, write strobe writes.
// - Non-multiplexed: address from eight address inputs, data on eight lines.
// - Multiplexed: eight shared lines carry address then data.
// - Pending mailbox interrupt shown on one open-drain low-active output.
module hpbp_host_port #(
	parameter int DATA_W = hpbp_pkg::HPBP_DATA_W,
	parameter int ADDR_W = hpbp_pkg::HPBP_ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              chip_sel_n,
	input  wire logic              addr_latch,
	input  wire logic              rd_n_data_strobe_n,
	input  wire logic              wr_n_rd_wr,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] ad_in,
	output logic      [DATA_W-1:0] ad_out,
	output logic      [DATA_W-1:0] ad_oe_n,
	input  wire logic              irq_pending,
	output logic                   irq_out,
	output logic                   irq_oe_n,
	output logic      [1:0]        bus_type,
	output logic      [ADDR_W-1:0] loc_addr,
	output logic      [DATA_W-1:0] loc_wdata,
	output logic                   loc_wr,
	output logic                   loc_rd,
	input  wire logic [DATA_W-1:0] loc_rdata
);
	initial begin
		if (DATA_W != 8 || ADDR_W != 8) begin
			$error("hpbp_host_port serves only an eight-bit port");
		end
	end

	hpbp_pkg::hpbp_bus_t bus_reg, bus_next;
	logic                strap_done_reg, strap_done_next;
	logic                ale_q, ale_rise, ale_fall;
	logic                ds_q, ds_rise, ds_fall;
	logic                wr_q, wr_rise, wr_fall;
	logic [ADDR_W-1:0]   latch_addr_reg, latch_addr_next;
	logic [ADDR_W-1:0]   loc_addr_reg, loc_addr_next;
	logic [DATA_W-1:0]   loc_wdata_reg, loc_wdata_next;
	logic                loc_wr_reg, loc_wr_next;
	logic                loc_rd_reg, loc_rd_next;
	logic [DATA_W-1:0]   ad_out_reg, ad_out_next;
	logic [DATA_W-1:0]   ad_oe_n_reg, ad_oe_n_next;
	logic                irq_oe_n_reg, irq_oe_n_next;
	logic                rd_active;
	logic [ADDR_W-1:0]   cur_addr;

	// Edge detectors on the latch pin and the two strobes.
	hpbp_strobe_edge u_ale (
		.clk        (clk),
		.nrst       (nrst),
		.level_in   (addr_latch),
		.reset_value(1'b1),
		.level_q    (ale_q),
		.rise       (ale_rise),
		.fall       (ale_fall)
	);
	hpbp_strobe_edge u_ds (
		.clk        (clk),
		.nrst       (nrst),
		.level_in   (rd_n_data_strobe_n),
		.reset_value(1'b1),
		.level_q    (ds_q),
		.rise       (ds_rise),
		.fall       (ds_fall)
	);
	hpbp_strobe_edge u_wr (
		.clk        (clk),
		.nrst       (nrst),
		.level_in   (wr_n_rd_wr),
		.reset_value(1'b1),
		.level_q    (wr_q),
		.rise       (wr_rise),
		.fall       (wr_fall)
	);

	// Address of the access in the current flavour.
	function automatic logic [ADDR_W-1:0] pick_addr(input hpbp_pkg::hpbp_bus_t b,
			input logic [ADDR_W-1:0] latched, input logic [ADDR_W-1:0] direct);
		pick_addr = (b == hpbp_pkg::HPBP_BUS_MUXED) ? latched : direct;
	endfunction

	assign cur_addr = pick_addr(bus_reg, latch_addr_reg, addr_in);

	// A read is active while selected and the read strobe is low, with direction high in the strobe flavour.
	always_comb begin
		if (chip_sel_n) begin
			rd_active = 1'b0;
		end else if (bus_reg == hpbp_pkg::HPBP_BUS_STROBE_DIR) begin
			rd_active = wr_n_rd_wr & ~rd_n_data_strobe_n;
		end else begin
			rd_active = ~rd_n_data_strobe_n;
		end
	end

	// Bus flavour: strap is caught on the first clock after reset, edges then force muxed.
	// The strap uses the pin sample, not the edge detector, since the detector idles high.
	always_comb begin
		bus_next        = bus_reg;
		strap_done_next = 1'b1;
		if (!strap_done_reg) begin
			bus_next = addr_latch ? hpbp_pkg::HPBP_BUS_STROBE_DIR
				: hpbp_pkg::HPBP_BUS_SPLIT;
		end else if (ale_rise || ale_fall) begin
			bus_next = hpbp_pkg::HPBP_BUS_MUXED;
		end
		if (bus_reg == hpbp_pkg::HPBP_BUS_MUXED) begin
			bus_next = hpbp_pkg::HPBP_BUS_MUXED;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_reg        <= hpbp_pkg::HPBP_BUS_STROBE_DIR;
			strap_done_reg <= 1'b0;
		end else begin
			bus_reg        <= bus_next;
			strap_done_reg <= strap_done_next;
		end
	end

	// Address capture follows the latch while high and freezes when it falls.
	always_comb begin
		latch_addr_next = latch_addr_reg;
		if (addr_latch && strap_done_reg && (bus_reg == hpbp_pkg::HPBP_BUS_MUXED
				|| ale_rise || ale_fall)) begin
			latch_addr_next = ad_in;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			latch_addr_reg <= hpbp_pkg::HPBP_ADDR_RESET;
		end else begin
			latch_addr_reg <= latch_addr_next;
		end
	end

	// Access side: write pulses at the end of the strobe, read pulse at its start.
	// Writes are taken at strobe release so the host's data has settled.
	always_comb begin
		loc_addr_next  = loc_addr_reg;
		loc_wdata_next = loc_wdata_reg;
		loc_wr_next    = 1'b0;
		loc_rd_next    = 1'b0;
		if (!chip_sel_n) begin
			case (bus_reg)
				hpbp_pkg::HPBP_BUS_STROBE_DIR: begin
					if (ds_fall && wr_n_rd_wr) begin
						loc_rd_next   = 1'b1;
						loc_addr_next = cur_addr;
					end
					if (ds_rise && !wr_n_rd_wr) begin
						loc_wr_next    = 1'b1;
						loc_addr_next  = cur_addr;
						loc_wdata_next = ad_in;
					end
				end
				hpbp_pkg::HPBP_BUS_SPLIT, hpbp_pkg::HPBP_BUS_MUXED: begin
					if (ds_fall) begin
						loc_rd_next   = 1'b1;
						loc_addr_next = cur_addr;
					end
					if (wr_rise) begin
						loc_wr_next    = 1'b1;
						loc_addr_next  = cur_addr;
						loc_wdata_next = ad_in;
					end
				end
				default: begin
					loc_wr_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loc_addr_reg  <= hpbp_pkg::HPBP_ADDR_RESET;
			loc_wdata_reg <= hpbp_pkg::HPBP_DATA_RESET;
			loc_wr_reg    <= 1'b0;
			loc_rd_reg    <= 1'b0;
		end else begin
			loc_addr_reg  <= loc_addr_next;
			loc_wdata_reg <= loc_wdata_next;
			loc_wr_reg    <= loc_wr_next;
			loc_rd_reg    <= loc_rd_next;
		end
	end

	// Pin drive: data only during a selected read; interrupt only pulls low.
	// The host must keep to locations up to 08h; others read back zero.
	always_comb begin
		ad_out_next   = hpbp_pkg::HPBP_DATA_RESET;
		ad_oe_n_next  = hpbp_pkg::HPBP_OE_OFF;
		irq_oe_n_next = ~irq_pending;
		if (rd_active) begin
			ad_oe_n_next = hpbp_pkg::HPBP_OE_ON;
			if (cur_addr <= hpbp_pkg::HPBP_LAST_LOC) begin
				ad_out_next = loc_rdata;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ad_out_reg   <= hpbp_pkg::HPBP_DATA_RESET;
			ad_oe_n_reg  <= hpbp_pkg::HPBP_OE_OFF;
			irq_oe_n_reg <= 1'b1;
		end else begin
			ad_out_reg   <= ad_out_next;
			ad_oe_n_reg  <= ad_oe_n_next;
			irq_oe_n_reg <= irq_oe_n_next;
		end
	end

	assign ad_out    = ad_out_reg;
	assign ad_oe_n   = ad_oe_n_reg;
	assign irq_out   = 1'b0;
	assign irq_oe_n  = irq_oe_n_reg;
	assign bus_type  = bus_reg;
	assign loc_addr  = loc_addr_reg;
	assign loc_wdata = loc_wdata_reg;
	assign loc_wr    = loc_wr_reg;
	assign loc_rd    = loc_rd_reg;

	// Registered strobe levels are kept for visibility only.
	logic unused_levels;
	assign unused_levels = ale_q ^ ds_q ^ wr_q ^ wr_fall;
endmodule // hpbp_host_port
`default_nettype wire

// ===== hpbp_checker_properties.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the host port pins; sees only the top module's ports.
module hpbp_checker (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       chip_sel_n,
	input wire logic       addr_latch,
	input wire logic       wr_n_rd_wr,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] ad_in,
	input wire logic [7:0] ad_oe_n,
	input wire logic       irq_pending,
	input wire logic       irq_out,
	input wire logic       irq_oe_n,
	input wire logic [1:0] bus_type,
	input wire logic [7:0] loc_addr,
	input wire logic [7:0] loc_wdata,
	input wire logic       loc_wr,
	input wire logic       loc_rd
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// A write pulse must follow a selected strobe, so a stray cycle shows here.
	sequence s_sel_wr; !$past(chip_sel_n) ##0 loc_wr; endsequence
	sequence s_latch_edge; $changed(addr_latch); endsequence
	a_cs_gates_wr: assert property (loc_wr |-> s_sel_wr ##1 !loc_wr)
		else $error("write pulse without chip select");
	a_rd_drive_sel: assert property (ad_oe_n != 8'hff |->
		ad_oe_n == 8'h00 && !$past(chip_sel_n)) else $error("data lines driven unselected");
	a_irq_open_drain: assert property (irq_oe_n == !$past(irq_pending) && irq_out == 1'b0)
		else $error("interrupt line wrong");
	a_mux_sticky: assert property (bus_type == 2'd2 |=> bus_type == 2'd2)
		else $error("multiplexed flavour left");
	a_edge_to_mux: assert property (s_latch_edge |-> ##[1:2] bus_type == 2'd2)
		else $error("latch edge did not select multiplexed flavour");
	a_wr_dir_low: assert property (loc_wr && bus_type == 2'd0 |-> !$past(wr_n_rd_wr))
		else $error("write with read direction");
	a_wr_data_taken: assert property (loc_wr |-> loc_wdata == $past(ad_in))
		else $error("write data not from data lines");
	a_rd_single_pulse: assert property (loc_rd |-> !loc_wr ##1 !loc_rd)
		else $error("read pulse longer than one cycle");
	a_wr_addr_direct: assert property (loc_wr && bus_type != 2'd2 |->
		loc_addr == $past(addr_in)) else $error("address not from address inputs");
endmodule // hpbp_checker
bind hpbp_host_port hpbp_checker u_chk (.*);
`default_nettype wire

// ===== hpbp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor model; each call runs one whole bus cycle.
module hpbp_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] ad_out,
	input  wire logic [7:0] ad_oe_n,
	output logic            chip_sel_n,
	output logic            addr_latch,
	output logic            rd_n_data_strobe_n,
	output logic            wr_n_rd_wr,
	output logic [7:0]      addr_in,
	output logic [7:0]      ad_in
);
	logic [7:0] host_ad;
	// Idle bus at time zero, strapped for the strobe and direction flavour.
	initial begin
		chip_sel_n = 1'b1;
		addr_latch = 1'b1;
		rd_n_data_strobe_n = 1'b1;
		wr_n_rd_wr = 1'b1;
		addr_in = 8'hff;
		host_ad = 8'h00;
	end
	// Each line shows the device while it drives, else the host value.
	assign ad_in = (ad_oe_n & host_ad) | (~ad_oe_n & ad_out);
	// One access in flavour bt; sel_n high makes a stray unselected cycle.
	task automatic xfer(input logic [1:0] bt, input logic we, input logic [7:0] a,
			input logic [7:0] d, input logic sel_n, output logic [7:0] q);
		if (bt == 2'd2) begin
			host_ad <= a;
			addr_latch <= 1'b1;
			repeat (2) @(posedge clk);
			addr_latch <= 1'b0;
			@(posedge clk);
		end
		chip_sel_n <= sel_n;
		addr_in <= (bt == 2'd2) ? 8'hff : a;
		host_ad <= we ? d : ~host_ad;
		if (bt == 2'd0) wr_n_rd_wr <= ~we;
		if (bt == 2'd0 || !we) rd_n_data_strobe_n <= 1'b0;
		else wr_n_rd_wr <= 1'b0;
		repeat (4) @(posedge clk);
		q = ad_in;
		rd_n_data_strobe_n <= 1'b1;
		if (bt != 2'd0) wr_n_rd_wr <= 1'b1;
		@(posedge clk);
		chip_sel_n <= 1'b1;
		wr_n_rd_wr <= 1'b1;
		host_ad <= ~host_ad; // Released lines drift away from the last value.
		repeat (2) @(posedge clk);
	endtask
endmodule // hpbp_host_model
`default_nettype wire

// ===== host_parallel_bus_port_test.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the host port.
module host_parallel_bus_port_test;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic       irq_pending = 1'b0;
	logic       chip_sel_n, addr_latch, rd_n_data_strobe_n, wr_n_rd_wr;
	logic       loc_wr, loc_rd, irq_out, irq_oe_n;
	logic [7:0] addr_in, ad_in, ad_out, ad_oe_n, loc_addr, loc_wdata, q, wa, wd, ra;
	logic [1:0] bus_type;
	int         error_cnt = 0;
	int         comparisons = 0;
	int         cycles = 0;
	wire  [7:0] loc_rdata = loc_addr ^ 8'h5a;
	always #20 clk = ~clk;
	hpbp_host_port u_dut (.*);
	hpbp_host_model u_host (.*);
	// Keeps the last mailbox write; the cycle ceiling cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (loc_wr === 1'b1) begin
			wa <= loc_addr;
			wd <= loc_wdata;
		end
		if (loc_rd === 1'b1) begin
			ra <= loc_addr;
		end
		if (cycles == 3000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic do_reset(input logic strap);
		nrst <= 1'b0;
		u_host.addr_latch <= strap;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// Strobe and direction flavour: write, then read back.
	task automatic t_strobe_dir();
		check({6'h00, bus_type}, 8'h00);
		u_host.xfer(2'd0, 1'b1, 8'h03, 8'ha5, 1'b0, q);
		check(wa, 8'h03);
		check(wd, 8'ha5);
		u_host.xfer(2'd0, 1'b0, 8'h03, 8'h00, 1'b0, q);
		check(q, 8'h59);
	endtask
	// Split flavour with a stray cycle, a reserved read and the interrupt.
	task automatic t_split();
		do_reset(1'b0);
		check({6'h00, bus_type}, 8'h01);
		u_host.xfer(2'd1, 1'b1, 8'h08, 8'h3c, 1'b0, q);
		check(wd, 8'h3c);
		u_host.xfer(2'd1, 1'b1, 8'h02, 8'hff, 1'b1, q);
		check(wa, 8'h08);
		u_host.xfer(2'd1, 1'b0, 8'h08, 8'h00, 1'b0, q);
		check(q, 8'h52);
		u_host.xfer(2'd1, 1'b0, 8'h09, 8'h00, 1'b0, q);
		check(q, 8'h00);
		irq_pending <= 1'b1;
		repeat (2) @(posedge clk);
		check({7'h00, irq_oe_n}, 8'h00);
		irq_pending <= 1'b0;
	endtask
	// A latch edge selects the multiplexed flavour until the next reset.
	task automatic t_muxed();
		u_host.xfer(2'd2, 1'b1, 8'h05, 8'hc3, 1'b0, q);
		check({6'h00, bus_type}, 8'h02);
		check(wa, 8'h05);
		check(wd, 8'hc3);
		u_host.xfer(2'd2, 1'b0, 8'h07, 8'h00, 1'b0, q);
		check(q, 8'h5d);
		check(ra, 8'h07);
		repeat (50) @(posedge clk);
		check({6'h00, bus_type}, 8'h02);
		do_reset(1'b1);
		check({6'h00, bus_type}, 8'h00);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_strobe_dir();
		t_split();
		t_muxed();
		close_out();
	end
endmodule // host_parallel_bus_port_test
`default_nettype wire
